// file: hdl/srd_pkg.sv
// package: opcodes, cycle counts and flag positions for the stack and rotate decoder
package srd_pkg;
    localparam logic [7:0] OP_STACK_PULL_LONG = 8'hd8;
    localparam logic [7:0] OP_PUSH_REG = 8'h70;
    localparam logic [7:0] OP_PUSH_IND = 8'h71;
    localparam logic [7:0] OP_LITERAL_PREFIX = 8'h1f;
    localparam logic [7:0] OP_STACK_STORE_LONG = 8'hc8;
    localparam logic [7:0] OP_SUBROUTINE_EXIT = 8'haf;
    localparam logic [7:0] OP_ROT_LEFT_REG = 8'h10;
    localparam logic [7:0] OP_ROT_LEFT_IND = 8'h11;
    localparam logic [7:0] OP_ROT_RIGHT_REG = 8'hc0;
    localparam logic [7:0] OP_ROT_RIGHT_IND = 8'hc1;
    localparam logic [2:0] FETCH_1 = 3'h1;
    localparam logic [2:0] FETCH_2 = 3'h2;
    localparam logic [2:0] FETCH_3 = 3'h3;
    localparam logic [2:0] EXEC_2 = 3'h2;
    localparam logic [2:0] EXEC_3 = 3'h3;
    localparam logic [2:0] EXEC_4 = 3'h4;
    localparam int FLAG_C = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_S = 5;
    localparam int FLAG_V = 4;
    localparam int FLAG_D = 3;
    localparam int FLAG_H = 2;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] STACK_POINTER_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;
    typedef enum logic [3:0] {
        SRD_NONE, SRD_PULL_LONG, SRD_PUSH_REG, SRD_PUSH_IND, SRD_PUSH_LIT,
        SRD_PUSH_LONG, SRD_EXIT, SRD_ROT_LEFT_REG, SRD_ROT_LEFT_IND, SRD_ROT_RIGHT_REG,
        SRD_ROT_RIGHT_IND
    } srd_op_t;
endpackage

// file: hdl/srd_rotate.sv
// rotate through carry unit with flag results
`timescale 1ns/1ps
module srd_rotate
    import srd_pkg::*;
(
    input wire logic [7:0] operand,
    input wire logic carry_in,
    input wire logic dir_right,
    output logic [7:0] result,
    output logic carry_out,
    output logic zero_out,
    output logic sign_out,
    output logic ovf_out
);
    always_comb begin
        if (dir_right) begin
            result = {carry_in, operand[7:1]};
            carry_out = operand[0];
        end else begin
            result = {operand[6:0], carry_in};
            carry_out = operand[7];
        end
        zero_out = (result == 8'h00);
        sign_out = result[7];
        ovf_out = result[7] ^ operand[7];
    end
endmodule

// file: hdl/srd_core.sv
// stack pull/push, subroutine exit and rotate-through-carry decode and execute
//
// Function
// - long pull: dst gets byte at stack top, then pointer plus one; 3+2 cycles
// - short push: pointer minus one, store source; reg 2+2, indirect 2+3, literal 3+2
// - long push: pointer minus one, store 12-bit addressed byte; 3+2 cycles
// - exit: program counter from two stack bytes, pointer plus two; 1+4 cycles
// - rotate left: bit 7 to carry, carry to bit 0; C Z S V updated
// - rotate right: bit 0 to carry, carry to bit 7; C Z S V updated
// - affected flags follow result; unaffected flags keep their values
`timescale 1ns/1ps
module srd_core
    import srd_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic fetch_valid,
    input wire logic [7:0] fetch_byte,
    output logic fetch_ready,
    output logic mem_req,
    output logic mem_we,
    output logic [11:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    output logic [11:0] ext_dst_addr,
    output logic [7:0] ext_dst_data,
    output logic ext_dst_we,
    output logic [7:0] stack_pointer,
    output logic [15:0] prog_counter,
    output logic [7:0] flags,
    output logic busy,
    output logic done,
    output logic illegal
);
    typedef enum logic [1:0] {SRD_FETCH, SRD_EXEC} srd_phase_t;

    srd_phase_t phase_q;
    srd_op_t op_q;
    logic [2:0] fcnt_q;
    logic [2:0] ecnt_q;
    logic [23:0] opnd_q;
    logic [7:0] data_q;
    logic [7:0] stk_ptr_q;
    logic [7:0] ptr_q;
    logic [15:0] pc_q;
    logic [7:0] flags_q;
    logic done_q;
    logic illegal_q;
    logic prefix_q;
    logic [7:0] rot_result;
    logic rot_c, rot_z, rot_s, rot_v;
    logic is_right;

    function automatic srd_op_t decode_op(input logic [7:0] b, input logic pfx);
        if (pfx) begin
            return (b == OP_PUSH_REG) ? SRD_PUSH_LIT : SRD_NONE;
        end
        unique case (b)
            OP_STACK_PULL_LONG: return SRD_PULL_LONG;
            OP_PUSH_REG: return SRD_PUSH_REG;
            OP_PUSH_IND: return SRD_PUSH_IND;
            OP_STACK_STORE_LONG: return SRD_PUSH_LONG;
            OP_SUBROUTINE_EXIT: return SRD_EXIT;
            OP_ROT_LEFT_REG: return SRD_ROT_LEFT_REG;
            OP_ROT_LEFT_IND: return SRD_ROT_LEFT_IND;
            OP_ROT_RIGHT_REG: return SRD_ROT_RIGHT_REG;
            OP_ROT_RIGHT_IND: return SRD_ROT_RIGHT_IND;
            default: return SRD_NONE;
        endcase
    endfunction

    function automatic logic [2:0] fetch_len(input srd_op_t op);
        unique case (op)
            SRD_PULL_LONG, SRD_PUSH_LONG, SRD_PUSH_LIT: return FETCH_3;
            SRD_EXIT: return FETCH_1;
            default: return FETCH_2;
        endcase
    endfunction

    function automatic logic [2:0] exec_len(input srd_op_t op);
        unique case (op)
            SRD_PUSH_IND, SRD_ROT_LEFT_IND, SRD_ROT_RIGHT_IND: return EXEC_3;
            SRD_EXIT: return EXEC_4;
            default: return EXEC_2;
        endcase
    endfunction

    assign is_right = (op_q == SRD_ROT_RIGHT_REG) || (op_q == SRD_ROT_RIGHT_IND);

    srd_rotate u_rot (
        .operand(data_q),
        .carry_in(flags_q[FLAG_C]),
        .dir_right(is_right),
        .result(rot_result),
        .carry_out(rot_c),
        .zero_out(rot_z),
        .sign_out(rot_s),
        .ovf_out(rot_v)
    );

    assign fetch_ready = (phase_q == SRD_FETCH);
    assign busy = (phase_q == SRD_EXEC) || (fcnt_q != 3'h0) || prefix_q;
    assign stack_pointer = stk_ptr_q;
    assign prog_counter = pc_q;
    assign flags = flags_q;
    assign done = done_q;
    assign illegal = illegal_q;

    // fetch sequencing: opcode byte, after any literal prefix, decodes, remaining operand bytes collected
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            phase_q <= SRD_FETCH;
            op_q <= SRD_NONE;
            fcnt_q <= 3'h0;
            ecnt_q <= 3'h0;
            opnd_q <= 24'h000000;
            prefix_q <= 1'b0;
            illegal_q <= 1'b0;
        end else begin
            illegal_q <= 1'b0;
            if (phase_q == SRD_FETCH && fetch_valid) begin
                if (fcnt_q == 3'h0 && !prefix_q && fetch_byte == OP_LITERAL_PREFIX) begin
                    prefix_q <= 1'b1;
                    fcnt_q <= 3'h1;
                end else if (fcnt_q == 3'h0 || (prefix_q && fcnt_q == 3'h1)) begin
                    prefix_q <= 1'b0;
                    op_q <= decode_op(fetch_byte, prefix_q);
                    if (decode_op(fetch_byte, prefix_q) == SRD_NONE) begin
                        illegal_q <= 1'b1;
                        fcnt_q <= 3'h0;
                    end else if (fetch_len(decode_op(fetch_byte, prefix_q)) ==
                                 (prefix_q ? FETCH_2 : FETCH_1)) begin
                        phase_q <= SRD_EXEC;
                        ecnt_q <= 3'h1;
                        fcnt_q <= 3'h0;
                    end else begin
                        fcnt_q <= fcnt_q + 3'h1;
                    end
                end else begin
                    opnd_q <= {opnd_q[15:0], fetch_byte};
                    if (fcnt_q + 3'h1 == fetch_len(op_q)) begin
                        phase_q <= SRD_EXEC;
                        ecnt_q <= 3'h1;
                        fcnt_q <= 3'h0;
                    end else begin
                        fcnt_q <= fcnt_q + 3'h1;
                    end
                end
            end else if (phase_q == SRD_EXEC) begin
                if (ecnt_q == exec_len(op_q)) begin
                    phase_q <= SRD_FETCH;
                    ecnt_q <= 3'h0;
                end else begin
                    ecnt_q <= ecnt_q + 3'h1;
                end
            end
        end
    end

    // memory port: reads in early execute cycles, writes in the last one
    always_comb begin
        mem_req = 1'b0;
        mem_we = 1'b0;
        mem_addr = 12'h000;
        mem_wdata = 8'h00;
        if (phase_q == SRD_EXEC) begin
            unique case (op_q)
                SRD_PULL_LONG: begin
                    mem_req = (ecnt_q == 3'h1);
                    mem_addr = {4'h0, stk_ptr_q};
                end
                SRD_PUSH_REG, SRD_PUSH_LONG, SRD_PUSH_LIT: begin
                    mem_req = 1'b1;
                    mem_we = (ecnt_q == 3'h2);
                    mem_addr = (ecnt_q == 3'h1) ?
                        ((op_q == SRD_PUSH_LONG) ? opnd_q[11:0] : {4'h0, opnd_q[7:0]}) :
                        {4'h0, stk_ptr_q};
                    mem_wdata = (op_q == SRD_PUSH_LIT) ? opnd_q[7:0] : data_q;
                    if (op_q == SRD_PUSH_LIT && ecnt_q == 3'h1) begin
                        mem_req = 1'b0;
                    end
                end
                SRD_PUSH_IND: begin
                    mem_req = 1'b1;
                    mem_we = (ecnt_q == 3'h3);
                    mem_addr = (ecnt_q == 3'h1) ? {4'h0, opnd_q[7:0]} :
                               (ecnt_q == 3'h2) ? {4'h0, data_q} : {4'h0, stk_ptr_q};
                    mem_wdata = data_q;
                end
                SRD_EXIT: begin
                    mem_req = (ecnt_q <= 3'h2);
                    mem_addr = {4'h0, stk_ptr_q + {7'h00, ecnt_q == 3'h2}};
                end
                SRD_ROT_LEFT_REG, SRD_ROT_RIGHT_REG, SRD_ROT_LEFT_IND, SRD_ROT_RIGHT_IND: begin
                    mem_req = 1'b1;
                    mem_we = (ecnt_q == exec_len(op_q));
                    mem_addr = (ecnt_q == 3'h2) ? {4'h0, data_q} : {4'h0, ptr_q};
                    if (ecnt_q == 3'h1 || exec_len(op_q) == EXEC_2) begin
                        mem_addr = {4'h0, opnd_q[7:0]};
                    end
                    mem_wdata = rot_result;
                end
                default: begin
                    mem_req = 1'b0;
                end
            endcase
        end
    end

    // data latch: operand byte or indirect pointer taken from memory
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            data_q <= 8'h00;
            ptr_q <= 8'h00;
        end else begin
            if (mem_req && !mem_we) begin
                data_q <= mem_rdata;
            end
            // indirect rotate keeps its pointer for the write-back cycle
            if (phase_q == SRD_EXEC && ecnt_q == 3'h2) begin
                ptr_q <= data_q;
            end
        end
    end

    // pointer, program counter and flags
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stk_ptr_q <= STACK_POINTER_RESET;
            pc_q <= PC_RESET;
            flags_q <= FLAGS_RESET;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (phase_q == SRD_EXEC) begin
                unique case (op_q)
                    SRD_PULL_LONG: begin
                        if (ecnt_q == 3'h2) begin
                            stk_ptr_q <= stk_ptr_q + 8'h01;
                        end
                    end
                    SRD_PUSH_REG, SRD_PUSH_LONG, SRD_PUSH_LIT, SRD_PUSH_IND: begin
                        if (ecnt_q == 3'h1) begin
                            stk_ptr_q <= stk_ptr_q - 8'h01;
                        end
                    end
                    SRD_EXIT: begin
                        if (ecnt_q == 3'h1) begin
                            pc_q[15:8] <= mem_rdata;
                        end
                        if (ecnt_q == 3'h2) begin
                            pc_q[7:0] <= mem_rdata;
                        end
                        if (ecnt_q == 3'h4) begin
                            stk_ptr_q <= stk_ptr_q + 8'h02;
                        end
                    end
                    SRD_ROT_LEFT_REG, SRD_ROT_RIGHT_REG, SRD_ROT_LEFT_IND, SRD_ROT_RIGHT_IND: begin
                        if (ecnt_q == exec_len(op_q)) begin
                            flags_q[FLAG_C] <= rot_c;
                            flags_q[FLAG_Z] <= rot_z;
                            flags_q[FLAG_S] <= rot_s;
                            flags_q[FLAG_V] <= rot_v;
                        end
                    end
                    default: begin
                        stk_ptr_q <= stk_ptr_q;
                    end
                endcase
                if (ecnt_q == exec_len(op_q)) begin
                    done_q <= 1'b1;
                end
            end
        end
    end

    // long pull destination write
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ext_dst_addr <= 12'h000;
            ext_dst_data <= 8'h00;
            ext_dst_we <= 1'b0;
        end else begin
            ext_dst_we <= 1'b0;
            if (phase_q == SRD_EXEC && op_q == SRD_PULL_LONG && ecnt_q == 3'h1) begin
                ext_dst_addr <= opnd_q[11:0];
                ext_dst_data <= mem_rdata;
                ext_dst_we <= 1'b1;
            end
        end
    end
endmodule

// file: tb/srd_core_assertions.sv
// port-level checks for the stack and rotate decoder
`timescale 1ns/1ps
module srd_core_assertions (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic fetch_ready,
    input wire logic ext_dst_we,
    input wire logic [7:0] stack_pointer,
    input wire logic [15:0] prog_counter,
    input wire logic [7:0] flags,
    input wire logic done
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_exec_min_two: assert property ($fell(fetch_ready) |=> !fetch_ready)
        else $error("execute phase under two cycles");
    a_exec_max_four: assert property ($fell(fetch_ready) |-> ##[1:4] fetch_ready)
        else $error("execute phase over four cycles");
    a_done_on_return: assert property ($rose(fetch_ready) |-> done)
        else $error("no done when execute ends");
    a_done_one_cycle: assert property (done |=> !done)
        else $error("done longer than one cycle");
    a_ext_one_cycle: assert property (ext_dst_we |=> !ext_dst_we)
        else $error("destination write longer than one cycle");
    a_ext_in_exec: assert property (ext_dst_we |-> !$past(fetch_ready))
        else $error("destination write outside execute");
    a_dh_flags_kept: assert property ($stable(flags[3:2]))
        else $error("decimal or half carry flag changed");
    a_stack_step_size: assert property ($changed(stack_pointer) |->
        stack_pointer == $past(stack_pointer) + 8'h01 ||
        stack_pointer == $past(stack_pointer) - 8'h01 ||
        stack_pointer == $past(stack_pointer) + 8'h02)
        else $error("stack pointer moved by a wrong step");
    a_regs_idle: assert property (fetch_ready && $past(fetch_ready) |->
        $stable(stack_pointer) && $stable(prog_counter) && $stable(flags))
        else $error("state changed outside execute");
endmodule
bind srd_core srd_core_assertions chk_u (.clock, .sys_rst, .fetch_ready, .ext_dst_we,
    .stack_pointer, .prog_counter, .flags, .done);

// file: tb/srd_core_tb.sv
// self-checking bench for the stack and rotate decoder
`timescale 1ns/1ps
module srd_core_tb;
    import srd_pkg::*;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic fetch_valid = 1'b0;
    logic [7:0] fetch_byte = 8'h00;
    logic fetch_ready, mem_req, mem_we, ext_dst_we, done, illegal, busy;
    logic [11:0] mem_addr, ext_dst_addr, ext_a;
    logic [7:0] mem_wdata, mem_rdata, ext_dst_data, ext_d, stack_pointer, flags;
    logic [15:0] prog_counter;
    logic [7:0] mem [4096];
    int n_fail = 0;
    int n_compared = 0;
    int n_done = 0;
    int n_ext = 0;
    int n_ill = 0;
    srd_core dut_u (.clock, .sys_rst, .fetch_valid, .fetch_byte, .fetch_ready, .mem_req,
        .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .ext_dst_addr, .ext_dst_data,
        .ext_dst_we, .stack_pointer, .prog_counter, .flags, .busy, .done, .illegal);
    assign mem_rdata = mem[mem_addr];
    initial forever #20 clock = ~clock;
    always @(posedge clock) if (mem_req === 1'b1 && mem_we === 1'b1) mem[mem_addr] <= mem_wdata;
    // pulse monitor, sampled mid-cycle
    always @(negedge clock) begin
        if (done === 1'b1) n_done++;
        if (illegal === 1'b1) n_ill++;
        if (ext_dst_we === 1'b1) begin
            n_ext++;
            ext_a = ext_dst_addr;
            ext_d = ext_dst_data;
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // feeds nb bytes, first in the top byte used, then counts execute cycles
    task automatic run(input logic [23:0] b, input int nb, input int ex, input int nd);
        int k;
        int d0;
        d0 = n_done;
        for (int i = nb - 1; i >= 0; i--) begin
            @(negedge clock);
            fetch_valid = 1'b1;
            fetch_byte = b[i*8 +: 8];
            @(posedge clock);
        end
        @(negedge clock);
        fetch_valid = 1'b0;
        check("busy", {15'h0, busy}, {15'h0, ex != 0});
        k = 0;
        while (fetch_ready === 1'b0 && k < 8) begin
            k++;
            @(negedge clock);
        end
        check("exec cycles", 16'(k), 16'(ex));
        @(negedge clock);
        check("done count", 16'(n_done - d0), 16'(nd));
        check("idle", {15'h0, busy}, 16'h0000);
    endtask
    task automatic t_rotate();
        mem[12'h020] = 8'h80;
        run({8'h00, OP_ROT_LEFT_REG, 8'h20}, 2, 2, 1);
        check("rotl result", {8'h00, mem[12'h020]}, 16'h0000);
        check("rotl flags", {8'h00, flags}, 16'h00d0);
        mem[12'h021] = 8'h30;
        mem[12'h030] = 8'h01;
        run({8'h00, OP_ROT_RIGHT_IND, 8'h21}, 2, 3, 1);
        check("rotr result", {8'h00, mem[12'h030]}, 16'h0080);
        check("rotr flags", {8'h00, flags}, 16'h00b0);
    endtask
    task automatic t_rotate_rest();
        mem[12'h024] = 8'h02;
        run({8'h00, OP_ROT_RIGHT_REG, 8'h24}, 2, 2, 1);
        check("rotr reg result", {8'h00, mem[12'h024]}, 16'h0081);
        check("rotr reg flags", {8'h00, flags}, 16'h0030);
        mem[12'h025] = 8'h40;
        mem[12'h040] = 8'hc1;
        run({8'h00, OP_ROT_LEFT_IND, 8'h25}, 2, 3, 1);
        check("rotl ind result", {8'h00, mem[12'h040]}, 16'h0082);
        check("rotl ind pointer", {8'h00, mem[12'h025]}, 16'h0040);
        check("rotl ind flags", {8'h00, flags}, 16'h00a0);
    endtask
    task automatic t_push_short();
        mem[12'h022] = 8'h5a;
        run({8'h00, OP_PUSH_REG, 8'h22}, 2, 2, 1);
        check("push reg", {stack_pointer, mem[12'h0ff]}, 16'hff5a);
        run({OP_LITERAL_PREFIX, OP_PUSH_REG, 8'ha5}, 3, 2, 1);
        check("push lit", {stack_pointer, mem[12'h0fe]}, 16'hfea5);
        run({8'h00, OP_PUSH_IND, 8'h21}, 2, 3, 1);
        check("push ind", {stack_pointer, mem[12'h0fd]}, 16'hfd80);
        check("push flags", {8'h00, flags}, 16'h00b0);
    endtask
    task automatic t_long();
        int e0;
        mem[12'h345] = 8'h3c;
        run({OP_STACK_STORE_LONG, 8'h03, 8'h45}, 3, 2, 1);
        check("push long", {stack_pointer, mem[12'h0fc]}, 16'hfc3c);
        e0 = n_ext;
        run({OP_STACK_PULL_LONG, 8'h0a, 8'hbc}, 3, 2, 1);
        check("pull writes", 16'(n_ext - e0), 16'h0001);
        check("pull addr", {4'h0, ext_a}, 16'h0abc);
        check("pull data", {stack_pointer, ext_d}, 16'hfd3c);
        check("long flags", {8'h00, flags}, 16'h00b0);
    endtask
    task automatic t_exit_and_illegal();
        int i0;
        run({16'h0000, OP_SUBROUTINE_EXIT}, 1, 4, 1);
        check("exit pc", prog_counter, 16'h80a5);
        check("exit stack", {stack_pointer, flags}, 16'hffb0);
        i0 = n_ill;
        run(24'h000000, 1, 0, 0);
        check("illegal", {stack_pointer, 8'(n_ill - i0)}, 16'hff01);
    endtask
    initial begin
        #20000;
        n_fail++;
        test_done();
    end
    initial begin
        for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
        repeat (5) @(negedge clock);
        sys_rst = 1'b0;
        check("reset", {stack_pointer, flags}, {STACK_POINTER_RESET, FLAGS_RESET});
        t_rotate();
        t_push_short();
        t_long();
        t_exit_and_illegal();
        t_rotate_rest();
        test_done();
    end
endmodule
